//--- logic/rimlm_regulator_irq_mask_and_load_meter.sv
// register bank: regulator interrupt masks and buck load-current meter
`timescale 1ns/1ps
`include "rimlm_cfg.svh"

// Function
// - buck pg-lost mask bit blocks pg interrupt
// - buck pg-regained mask bit blocks pg interrupt
// - buck overcurrent mask bit blocks overcurrent interrupt
// - buck masks never touch raw status bits
// - linreg pg-lost mask bit blocks pg interrupt
// - linreg pg-regained mask bit blocks pg interrupt
// - linreg overcurrent mask bit blocks overcurrent interrupt
// - linreg masks never touch raw status bits
// - select bit zero picks buck, resets zero
// - each select write starts new measurement
// - dual-phase master reports summed phase currents
// - slave reports its own phase only
// - result bit eight at bit zero, rest zero
// - low eight result bits separate, reset zero
// - completion raises ready flag unless masked
module rimlm_regulator_irq_mask_and_load_meter #(
    parameter int RESULT_W = 9          // width of the current result
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [7:0]   regAddr,
    input  wire logic         regWrite,
    input  wire logic [7:0]   regWdata,
    output logic      [7:0]   regRdata,
    input  wire logic [7:0]   factoryBuckMask,
    input  wire logic [7:0]   factoryLinregMask,
    input  wire logic [3:0]   pgInvalidPin,
    input  wire logic [3:0]   overcurrentPin,
    output logic      [3:0]   pgRaw,
    output logic      [3:0]   overcurrentRaw,
    output logic      [3:0]   pgIrqFlag,
    output logic      [3:0]   overcurrentIrqFlag,
    input  wire logic [3:0]   pgIrqClear,
    input  wire logic [3:0]   overcurrentIrqClear,
    output logic              measStart,
    output logic              measBuck,
    input  wire logic         measDonePin,
    input  wire logic [8:0]   firstPhaseCurrentPin,
    input  wire logic [8:0]   secondPhaseCurrentPin,
    input  wire logic         dualPhase,
    input  wire logic         secondBuckIsMaster,
    input  wire logic         measurementReadyIrqMask,
    output logic              measurementReadyIrqFlag,
    input  wire logic         measurementReadyIrqClear
);

    // ********************************************************
    // elaboration checks
    // ********************************************************
    // result split is fixed at eight low bits plus one high bit
    if (RESULT_W != 9) begin : g_bad_width
        $error("result width must be 9");
    end

    // ********************************************************
    // helper functions
    // ********************************************************
    // pick the three mask bits of one regulator pair entry
    function automatic logic [2:0] pick_mask(input logic [7:0] m,
                                             input logic       second);
        if (second) begin
            pick_mask = {m[`RIMLM_BIT_SECOND_PG_LOST],
                         m[`RIMLM_BIT_SECOND_PG_REGAINED],
                         m[`RIMLM_BIT_SECOND_OVERCURRENT]};
        end else begin
            pick_mask = {m[`RIMLM_BIT_FIRST_PG_LOST],
                         m[`RIMLM_BIT_FIRST_PG_REGAINED],
                         m[`RIMLM_BIT_FIRST_OVERCURRENT]};
        end
    endfunction

    // saturating sum of two phases, full scale is the top code
    function automatic logic [8:0] sat_sum(input logic [8:0] a,
                                           input logic [8:0] b);
        logic [9:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_sum = s[9] ? `RIMLM_RESULT_FULL_SCALE : s[8:0];
    endfunction

    // ********************************************************
    // pin synchronisers
    // ********************************************************
    logic [3:0] pgMeta_r;               // first stage, pg invalid
    logic [3:0] pgSync_r;               // second stage, pg invalid
    logic [3:0] ocMeta_r;               // first stage, overcurrent
    logic [3:0] ocSync_r;               // second stage, overcurrent
    logic       doneMeta_r;             // first stage, meter done
    logic       doneSync_r;             // second stage, meter done
    logic [8:0] firstMeta_r;            // first stage, phase 0 current
    logic [8:0] firstSync_r;            // second stage, phase 0 current
    logic [8:0] secondMeta_r;           // first stage, phase 1 current
    logic [8:0] secondSync_r;           // second stage, phase 1 current

    // all analog-side inputs pass two flops before any logic
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pgMeta_r     <= 4'h0;
            pgSync_r     <= 4'h0;
            ocMeta_r     <= 4'h0;
            ocSync_r     <= 4'h0;
            doneMeta_r   <= 1'h0;
            doneSync_r   <= 1'h0;
            firstMeta_r  <= 9'h000;
            firstSync_r  <= 9'h000;
            secondMeta_r <= 9'h000;
            secondSync_r <= 9'h000;
        end else begin
            pgMeta_r     <= pgInvalidPin;
            pgSync_r     <= pgMeta_r;
            ocMeta_r     <= overcurrentPin;
            ocSync_r     <= ocMeta_r;
            doneMeta_r   <= measDonePin;
            doneSync_r   <= doneMeta_r;
            firstMeta_r  <= firstPhaseCurrentPin;
            firstSync_r  <= firstMeta_r;
            secondMeta_r <= secondPhaseCurrentPin;
            secondSync_r <= secondMeta_r;
        end
    end

    // ********************************************************
    // raw status and edge detection
    // ********************************************************
    logic       doneSeen_r;             // previous synced done level

    // raw bits follow the conditions, masks never enter here
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pgRaw          <= 4'h0;
            overcurrentRaw <= 4'h0;
            doneSeen_r     <= 1'h0;
        end else begin
            pgRaw          <= pgSync_r;
            overcurrentRaw <= ocSync_r;
            doneSeen_r     <= doneSync_r;
        end
    end

    wire [3:0] pgLostEdge     = pgSync_r & ~pgRaw;   // valid to invalid
    wire [3:0] pgRegainedEdge = ~pgSync_r & pgRaw;   // invalid to valid
    wire [3:0] ocEdge         = ocSync_r & ~overcurrentRaw;
    wire       doneEdge       = doneSync_r & ~doneSeen_r;

    // ********************************************************
    // mask registers
    // ********************************************************
    logic [7:0] buckMask_r;             // buck interrupt masks
    logic [7:0] linregMask_r;           // linreg interrupt masks
    logic       masksLoaded_r;          // factory copy taken

    wire hitBuckMask   = (regAddr == `RIMLM_OFS_BUCK_MASKS);
    wire hitLinregMask = (regAddr == `RIMLM_OFS_LINREG_MASK);
    wire hitSelect     = (regAddr == `RIMLM_OFS_MEAS_SELECT);
    wire hitHigh       = (regAddr == `RIMLM_OFS_RESULT_HIGH);
    wire hitLow        = (regAddr == `RIMLM_OFS_RESULT_LOW);

    // factory straps are caught by the clock after release, not by
    // the reset itself, so the async branch only sees constants
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            buckMask_r    <= `RIMLM_RST_MASK;
            linregMask_r  <= `RIMLM_RST_MASK;
            masksLoaded_r <= 1'h0;
        end else if (!masksLoaded_r) begin
            // first edge after release: copy factory settings
            buckMask_r    <= factoryBuckMask & `RIMLM_MASK_WRITABLE;
            linregMask_r  <= factoryLinregMask & `RIMLM_MASK_WRITABLE;
            masksLoaded_r <= 1'h1;
        end else if (regWrite && hitBuckMask) begin
            buckMask_r    <= regWdata & `RIMLM_MASK_WRITABLE;
        end else if (regWrite && hitLinregMask) begin
            linregMask_r  <= regWdata & `RIMLM_MASK_WRITABLE;
        end
    end

    // ********************************************************
    // interrupt flag gating
    // ********************************************************
    // per regulator: {pg lost, pg regained, overcurrent} mask bits
    // index 0 first buck, 1 second buck, 2 first linreg, 3 second
    wire [2:0] maskOf [4];
    assign maskOf[0] = pick_mask(buckMask_r, 1'b0);
    assign maskOf[1] = pick_mask(buckMask_r, 1'b1);
    assign maskOf[2] = pick_mask(linregMask_r, 1'b0);
    assign maskOf[3] = pick_mask(linregMask_r, 1'b1);

    logic [3:0] pgSet;                  // unmasked pg events
    logic [3:0] ocSet;                  // unmasked overcurrent events

    // a set bit in the mask stops only the interrupt path
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pgSet[i] = (pgLostEdge[i] & ~maskOf[i][2])
                     | (pgRegainedEdge[i] & ~maskOf[i][1]);
            ocSet[i] = ocEdge[i] & ~maskOf[i][0];
        end
    end

    // sticky flags; an event in the clear cycle wins over the clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pgIrqFlag          <= 4'h0;
            overcurrentIrqFlag <= 4'h0;
        end else begin
            pgIrqFlag          <= pgSet | (pgIrqFlag & ~pgIrqClear);
            overcurrentIrqFlag <= ocSet
                                | (overcurrentIrqFlag & ~overcurrentIrqClear);
        end
    end

    // ********************************************************
    // measurement sequencer
    // ********************************************************
    rimlm_pkg::rimlm_meas_state_t measState_r;  // sequencer state
    logic [8:0] result_r;               // last captured result
    logic       measReadyEvent_r;       // one-cycle completion pulse

    wire selectWrite = regWrite && hitSelect;
    // the selected buck is master when dual-phase and it owns the pair
    wire selIsMaster = dualPhase && (measBuck == secondBuckIsMaster);
    wire [8:0] selPhase  = measBuck ? secondSync_r : firstSync_r;
    wire [8:0] measValue = selIsMaster
                         ? sat_sum(firstSync_r, secondSync_r)
                         : selPhase;

    // a new write restarts from scratch; the last result stays
    // readable until the new one is captured
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            measState_r      <= rimlm_pkg::RIMLM_IDLE;
            measBuck         <= `RIMLM_RST_SELECT;
            measStart        <= 1'h0;
            result_r         <= `RIMLM_RST_RESULT;
            measReadyEvent_r <= 1'h0;
        end else begin
            measStart        <= selectWrite;
            measReadyEvent_r <= 1'h0;
            if (selectWrite) begin
                measBuck    <= regWdata[`RIMLM_BIT_BUCK_SELECT];
                measState_r <= rimlm_pkg::RIMLM_WAIT_DONE;
            end else begin
                case (measState_r)
                    rimlm_pkg::RIMLM_IDLE: begin
                        measState_r <= rimlm_pkg::RIMLM_IDLE;
                    end
                    rimlm_pkg::RIMLM_WAIT_DONE: begin
                        // values settle with done, take them next edge
                        if (doneEdge) begin
                            measState_r <= rimlm_pkg::RIMLM_CAPTURE;
                        end
                    end
                    rimlm_pkg::RIMLM_CAPTURE: begin
                        result_r         <= measValue;
                        measReadyEvent_r <= 1'h1;
                        measState_r      <= rimlm_pkg::RIMLM_IDLE;
                    end
                    default: begin
                        measState_r <= rimlm_pkg::RIMLM_IDLE;
                    end
                endcase
            end
        end
    end

    // ready flag, masked here by the mask input, set wins over clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            measurementReadyIrqFlag <= 1'h0;
        end else begin
            measurementReadyIrqFlag <=
                (measReadyEvent_r & ~measurementReadyIrqMask)
                | (measurementReadyIrqFlag & ~measurementReadyIrqClear);
        end
    end

    // ********************************************************
    // register read port
    // ********************************************************
    // unmapped offsets read zero; reserved bits read zero
    wire [7:0] readMux =
          hitBuckMask   ? buckMask_r
        : hitLinregMask ? linregMask_r
        : hitSelect     ? {7'h00, measBuck}
        : hitHigh       ? {7'h00, result_r[`RIMLM_BIT_RESULT_MSB]}
        : hitLow        ? result_r[7:0]
        : 8'h00;

    // read data is registered and follows the address one cycle late
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= readMux;
        end
    end

endmodule // rimlm_regulator_irq_mask_and_load_meter

//--- logic/rimlm_cfg.svh
// constants of the regulator irq mask and load meter register block
`ifndef RIMLM_CFG_SVH
`define RIMLM_CFG_SVH

// ********************************************************
// register offsets
// ********************************************************
`define RIMLM_OFS_BUCK_MASKS     8'h22
`define RIMLM_OFS_LINREG_MASK    8'h23
`define RIMLM_OFS_MEAS_SELECT    8'h24
`define RIMLM_OFS_RESULT_HIGH    8'h25
`define RIMLM_OFS_RESULT_LOW     8'h26

// ********************************************************
// mask field positions (same layout for buck and linreg)
// ********************************************************
`define RIMLM_BIT_SECOND_PG_LOST      7
`define RIMLM_BIT_SECOND_PG_REGAINED  6
`define RIMLM_BIT_SECOND_OVERCURRENT  4
`define RIMLM_BIT_FIRST_PG_LOST       3
`define RIMLM_BIT_FIRST_PG_REGAINED   2
`define RIMLM_BIT_FIRST_OVERCURRENT   0
`define RIMLM_MASK_WRITABLE           8'hdd

// ********************************************************
// select and result fields, reset values
// ********************************************************
`define RIMLM_BIT_BUCK_SELECT    0
`define RIMLM_BIT_RESULT_MSB     8
`define RIMLM_RST_MASK           8'h00
`define RIMLM_RST_SELECT         1'h0
`define RIMLM_RST_RESULT         9'h000
`define RIMLM_RESULT_FULL_SCALE  9'h1ff

`endif

//--- logic/rimlm_pkg.sv
// types of the regulator irq mask and load meter register block
package rimlm_pkg;

    // measurement sequencer states
    typedef enum logic [1:0] {
        RIMLM_IDLE,
        RIMLM_WAIT_DONE,
        RIMLM_CAPTURE
    } rimlm_meas_state_t;

endpackage

//--- tb/rimlm_monitor.sv
// port-level concurrent checks of the irq mask and load meter block
`timescale 1ns/1ps
module rimlm_monitor #(
    parameter int RESULT_W = 9              // width of the current result
) (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic [7:0] regAddr,
    input wire logic       regWrite,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic [3:0] pgInvalidPin,
    input wire logic [3:0] overcurrentPin,
    input wire logic [3:0] pgRaw,
    input wire logic [3:0] overcurrentRaw,
    input wire logic [3:0] pgIrqFlag,
    input wire logic [3:0] overcurrentIrqFlag,
    input wire logic [3:0] pgIrqClear,
    input wire logic       measStart,
    input wire logic       measBuck,
    input wire logic       measDonePin,
    input wire logic       measurementReadyIrqMask,
    input wire logic       measurementReadyIrqFlag
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ********************************************************
    // measurement start
    // ********************************************************
    a_select_starts: assert property (
        regWrite && regAddr == 8'h24
        |=> measStart && measBuck == $past(regWdata[0]))
        else $error("select write gave no start");
    a_start_has_cause: assert property (
        measStart |-> $past(regWrite && regAddr == 8'h24))
        else $error("start without select write");
    // ready flag may only follow a done edge with the mask clear;
    // the mask is sampled on the edge that sets the flag
    a_ready_cause: assert property (
        $rose(measurementReadyIrqFlag)
        |-> $past(measDonePin, 4) && !$past(measurementReadyIrqMask, 1))
        else $error("ready flag without done or while masked");
    // ********************************************************
    // raw status and interrupt flags
    // ********************************************************
    // pins held five samples settle every pipeline depth
    a_raw_follows: assert property (
        $stable({pgInvalidPin, overcurrentPin}) [*5]
        |-> {pgRaw, overcurrentRaw} == $past({pgInvalidPin, overcurrentPin}))
        else $error("raw status not following pins");
    a_pg_flag_cause: assert property (
        (pgIrqFlag & ~$past(pgIrqFlag) & ~(pgRaw ^ $past(pgRaw))) == 4'h0)
        else $error("pg flag set without raw change");
    a_oc_flag_cause: assert property (
        (overcurrentIrqFlag & ~$past(overcurrentIrqFlag)
         & ~(overcurrentRaw & ~$past(overcurrentRaw))) == 4'h0)
        else $error("overcurrent flag set without rising raw");
    a_pg_flag_sticky: assert property (
        ($past(pgIrqFlag) & ~$past(pgIrqClear) & ~pgIrqFlag) == 4'h0)
        else $error("pg flag dropped without clear");
    // ********************************************************
    // read-only result
    // ********************************************************
    a_high_upper_zero: assert property (
        $past(regAddr) == 8'h25 |-> regRdata[7:1] == 7'h00)
        else $error("result high upper bits not zero");
endmodule // rimlm_monitor

//--- tb/rimlm_meter_model.sv
// behavioural load-current meter facing the block's measurement pins
`timescale 1ns/1ps
module rimlm_meter_model (
    input  wire logic       clock,
    input  wire logic       measStart,
    input  wire logic [4:0] lag,
    input  wire logic [8:0] amps0,
    input  wire logic [8:0] amps1,
    output logic            measDonePin,
    output logic      [8:0] phase0Pin,
    output logic      [8:0] phase1Pin
);
    // ********************************************************
    // conversion timer
    // ********************************************************
    int  cnt = -12;                         // -12 means idle
    wire live = (cnt <= 0) && (cnt > -11);  // currents valid
    // a new start restarts the conversion, as the block expects
    always @(posedge clock) begin
        if (measStart)
            cnt <= int'(lag);
        else if (cnt > -12)
            cnt <= cnt - 1;
    end
    assign measDonePin = live && (cnt < 0);
    // outside the window show the inverse, never a stale value
    assign phase0Pin = live ? amps0 : ~amps0;
    assign phase1Pin = live ? amps1 : ~amps1;
endmodule // rimlm_meter_model

//--- tb/rimlm_regulator_irq_mask_and_load_meter_tb.sv
// self-checking bench of the irq mask and load meter block
`timescale 1ns/1ps
module rimlm_regulator_irq_mask_and_load_meter_tb;
    // ********************************************************
    // signals
    // ********************************************************
    logic        clock = 1'b0;            // 40 MHz
    logic        rst_n = 1'b0;            // active low
    logic [7:0]  regAddr = 8'h00;
    logic        regWrite = 1'b0;
    logic [7:0]  regWdata = 8'h00;
    logic [7:0]  regRdata, fBuck, fLin;   // read data, factory masks
    logic [3:0]  pgPin = 4'h0, ocPin = 4'h0, pgClr = 4'h0, ocClr = 4'h0;
    logic [3:0]  pgRaw, ocRaw, pgFlag, ocFlag;
    logic        measStart, measBuck, donePin, rdyFlag;
    logic [8:0]  cur0, cur1, amps0 = 9'h000, amps1 = 9'h000;
    logic [4:0]  lag = 5'h03;             // meter conversion delay
    logic        dual = 1'b0, master2 = 1'b0, rdyMask = 1'b0, rdyClr = 1'b0;
    logic [31:0] seed = 32'h70c49bd3;     // xorshift state
    int          nFail = 0;
    int          checksDone = 0;
    rimlm_regulator_irq_mask_and_load_meter #(.RESULT_W(9)) u_dut (
        .clock(clock), .rst_n(rst_n), .regAddr(regAddr),
        .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
        .factoryBuckMask(fBuck), .factoryLinregMask(fLin),
        .pgInvalidPin(pgPin), .overcurrentPin(ocPin), .pgRaw(pgRaw),
        .overcurrentRaw(ocRaw), .pgIrqFlag(pgFlag),
        .overcurrentIrqFlag(ocFlag), .pgIrqClear(pgClr),
        .overcurrentIrqClear(ocClr), .measStart(measStart),
        .measBuck(measBuck), .measDonePin(donePin),
        .firstPhaseCurrentPin(cur0), .secondPhaseCurrentPin(cur1),
        .dualPhase(dual), .secondBuckIsMaster(master2),
        .measurementReadyIrqMask(rdyMask),
        .measurementReadyIrqFlag(rdyFlag),
        .measurementReadyIrqClear(rdyClr));
    rimlm_meter_model u_meter (
        .clock(clock), .measStart(measStart), .lag(lag), .amps0(amps0),
        .amps1(amps1), .measDonePin(donePin), .phase0Pin(cur0),
        .phase1Pin(cur1));
    initial begin
        forever #12.5 clock = ~clock;
    end
    // ********************************************************
    // helpers and reference model
    // ********************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // master in dual phase sums both phases, saturating at full scale
    function automatic int expAmps(int s);
        int sum = amps0 + amps1;
        if (dual && s == int'(master2))
            return (sum > 511) ? 511 : sum;
        return (s == 1) ? int'(amps1) : int'(amps0);
    endfunction
    task automatic chk(string what, logic [8:0] seen, logic [8:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nFail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clock);
        regWrite = 1'b0;
    endtask
    // read data is registered: look one cycle after the address
    task automatic rc(string what, logic [7:0] a, logic [8:0] exp);
        @(negedge clock);
        regAddr = a;
        @(negedge clock);
        chk(what, {1'b0, regRdata}, exp);
    endtask
    task automatic clr(logic [3:0] p, logic [3:0] o, logic r);
        @(negedge clock);
        pgClr = p;
        ocClr = o;
        rdyClr = r;
        @(negedge clock);
        pgClr = 4'h0;
        ocClr = 4'h0;
        rdyClr = 1'b0;
    endtask
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ********************************************************
    // main sequence
    // ********************************************************
    initial begin
        logic [7:0] m, d, x;
        int sel, b;
        int j;
        fBuck = 8'(rnd());
        fLin = 8'(rnd());
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        repeat (2) @(negedge clock);
        rc("buck mask", 8'h22, {1'b0, fBuck & 8'hdd});
        rc("linreg mask", 8'h23, {1'b0, fLin & 8'hdd});
        rc("select", 8'h24, 9'h000);
        rc("result low", 8'h26, 9'h000);
        wr(8'h25, 8'hff);
        wr(8'h27, 8'hff);
        rc("result high", 8'h25, 9'h000);
        rc("unmapped", 8'h27, 9'h000);
        // buck masks all-clear, all-set, then random, linreg masks random, on every event kind
        for (int k = 0; k < 8; k++) begin
            m = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'(rnd());
            d = 8'(rnd());
            wr(8'h22, m);
            wr(8'h23, d);
            rc("buck mask", 8'h22, {1'b0, m & 8'hdd});
            rc("linreg mask", 8'h23, {1'b0, d & 8'hdd});
            for (int i = 0; i < 4; i++) begin
                x = (i < 2) ? m : d;
                b = (i % 2) * 4;
                clr(4'hf, 4'hf, 1'b0);
                pgPin[i] = 1'b1;
                ocPin[i] = 1'b1;
                repeat (6) @(negedge clock);
                chk("pg lost flag", pgFlag[i], !x[b + 3]);
                chk("oc flag", ocFlag[i], !x[b]);
                chk("raw", {pgRaw[i], ocRaw[i]}, 9'h003);
                clr(4'hf, 4'h0, 1'b0);
                pgPin[i] = 1'b0;
                ocPin[i] = 1'b0;
                repeat (6) @(negedge clock);
                chk("pg regained flag", pgFlag[i], !x[b + 2]);
                chk("oc flag held", ocFlag[i], !x[b]);
                chk("raw", {pgRaw[i], ocRaw[i]}, 9'h000);
            end
        end
        // every select, phase mode and master choice, some restarted
        for (int k = 0; k < 12; k++) begin
            sel = k % 2;
            dual = k[1];
            master2 = k[2];
            rdyMask = (k % 5 == 4);
            amps0 = 9'(rnd());
            amps1 = 9'(rnd());
            lag = 5'(3 + rnd() % 16);
            d = 8'(rnd());
            d[0] = sel[0];
            if (k % 3 == 0)
                wr(8'h24, ~d);
            wr(8'h24, d);
            chk("selected buck", measBuck, sel[0]);
            j = 0;
            while (rdyFlag !== 1'b1 && j < 40) begin
                @(negedge clock);
                j++;
            end
            chk("ready flag", rdyFlag, !rdyMask);
            rc("result high", 8'h25, 9'(expAmps(sel) >> 8));
            rc("result low", 8'h26, 9'(expAmps(sel) & 255));
            rc("select", 8'h24, 9'(sel));
            clr(4'h0, 4'h0, 1'b1);
        end
        giveVerdict();
    end
    // a hang ends the run as a mismatch
    initial begin
        repeat (20000) @(posedge clock);
        nFail++;
        giveVerdict();
    end
endmodule // rimlm_regulator_irq_mask_and_load_meter_tb

bind rimlm_regulator_irq_mask_and_load_meter rimlm_monitor #(
    .RESULT_W(RESULT_W)) u_mon (
    .clock(clock), .rst_n(rst_n), .regAddr(regAddr),
    .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
    .pgInvalidPin(pgInvalidPin), .overcurrentPin(overcurrentPin),
    .pgRaw(pgRaw), .overcurrentRaw(overcurrentRaw), .pgIrqFlag(pgIrqFlag),
    .overcurrentIrqFlag(overcurrentIrqFlag), .pgIrqClear(pgIrqClear),
    .measStart(measStart), .measBuck(measBuck), .measDonePin(measDonePin),
    .measurementReadyIrqMask(measurementReadyIrqMask),
    .measurementReadyIrqFlag(measurementReadyIrqFlag));
